// File: core/bms_device.sv
// Purpose: radio module boot mode selection from straps and configuration
// Assumes: I_CFG_ADDON is the configuration bit already read from eeprom
// Notes:   mode latched once per reset; I_VARIANT is a strap level held stable
`timescale 1ns/1ps
`include "bms_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module bms_device (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_N,
   bms_if.dev               B,
   input  wire logic        I_VARIANT,
   input  wire logic        I_OSC_STABLE,
   input  wire logic        I_CFG_ADDON,
   input  wire logic        I_LOAD_DONE,
   output logic [1:0]       O_MODE,
   output logic             O_BOOTED,
   output logic             O_STANDALONE,
   output logic             O_USE_SPI,
   output logic             O_USE_UART,
   output logic             O_VENDOR_HCI,
   output logic             O_AT_CMD,
   output logic             O_LOAD_REQ,
   output logic             O_RUN_APP,
   output logic             O_HOSTLESS,
   output logic             O_SLEEP,
   output logic             O_LINK_MASTER_OK,
   output logic [1:0]       O_MAX_LINKS
);
   bms_pkg::bms_dev_t r;
   bms_pkg::bms_dev_t next_r;
   bms_pkg::bms_mode_t pick;
   logic standalone_pick;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode from synchronised straps
   always_comb begin
      pick            = bms_pkg::BMS_MODE_HCI;
      standalone_pick = 1'b0;
      case ({I_VARIANT == `BMS_VARIANT_SPI, r.sel_s2, r.rx_s2})
         3'b100: begin
            pick = bms_pkg::BMS_MODE_VENDOR;
         end
         3'b110: begin
            pick = bms_pkg::BMS_MODE_VENDOR;
         end
         3'b101: begin
            pick = bms_pkg::BMS_MODE_HCI;
         end
         3'b111: begin
            pick = bms_pkg::BMS_MODE_HCI;
         end
         3'b000: begin
            pick            = bms_pkg::BMS_MODE_APP;
            standalone_pick = 1'b1;
         end
         3'b001: begin
            pick            = bms_pkg::BMS_MODE_APP;
            standalone_pick = !I_CFG_ADDON;
         end
         3'b011: begin
            pick = bms_pkg::BMS_MODE_HCI;
         end
         3'b010: begin
            pick = bms_pkg::BMS_MODE_HCI;
         end
         default: begin
            pick = bms_pkg::BMS_MODE_HCI;
         end
      endcase
   end

   always_comb begin
      next_r         = r;
      next_r.rx_s1   = B.rx;
      next_r.rx_s2   = r.rx_s1;
      next_r.sel_s1  = B.sel;
      next_r.sel_s2  = r.sel_s1;
      next_r.wake_s1 = B.wake;
      next_r.wake_s2 = r.wake_s1;
      case (r.st)
         bms_pkg::BMS_ST_RESET: begin
            next_r.st = bms_pkg::BMS_ST_OSC;
         end
         bms_pkg::BMS_ST_OSC: begin
            // straps need two cycles through the synchronisers
            if (r.osc_cnt != 5'(`BMS_OSC_WAIT_CYC)) begin
               next_r.osc_cnt = r.osc_cnt + 5'h01;
            end else if (I_OSC_STABLE) begin
               next_r.st         = bms_pkg::BMS_ST_RUN;
               next_r.mode       = pick;
               next_r.standalone = standalone_pick;
            end
         end
         bms_pkg::BMS_ST_RUN: begin
            // mode and standalone frozen here
            if (r.mode == bms_pkg::BMS_MODE_HCI) begin
               next_r.sleep = !r.wake_s2;
            end else begin
               next_r.sleep = 1'b0;
            end
         end
         default: begin
            next_r.st = bms_pkg::BMS_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r <= '{st:         bms_pkg::BMS_ST_RESET,
                osc_cnt:    5'h00,
                mode:       bms_pkg::BMS_MODE_NONE,
                standalone: 1'b0,
                default:    1'b0};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   logic run;
   logic in_vendor;
   logic in_hci;
   logic in_app;
   logic with_host;
   logic spi_variant;

   assign run         = (r.st == bms_pkg::BMS_ST_RUN);
   assign spi_variant = I_VARIANT == `BMS_VARIANT_SPI;

   ////////////////////////////////////////////////////////////////////////////
   // one-hot view of the latched mode
   always_comb begin
      in_vendor = 1'b0;
      in_hci    = 1'b0;
      in_app    = 1'b0;
      case (r.mode)
         bms_pkg::BMS_MODE_VENDOR: begin
            in_vendor = 1'b1;
         end
         bms_pkg::BMS_MODE_HCI: begin
            in_hci = 1'b1;
         end
         bms_pkg::BMS_MODE_APP: begin
            in_app = 1'b1;
         end
         default: begin
            in_app = 1'b0;
         end
      endcase
   end

   assign with_host = in_vendor || in_hci || (in_app && !r.standalone);

   ////////////////////////////////////////////////////////////////////////////
   // mode outputs
   always_comb begin
      O_MODE       = r.mode;
      O_BOOTED     = run;
      O_STANDALONE = in_app && r.standalone;
      O_USE_SPI    = in_vendor;
      O_USE_UART   = with_host;
      O_VENDOR_HCI = in_hci;
      O_AT_CMD     = in_app && !r.standalone;
      O_LOAD_REQ   = in_app && !I_LOAD_DONE;
      O_RUN_APP    = in_app && I_LOAD_DONE;
      O_HOSTLESS   = in_app && r.standalone;
      O_SLEEP      = r.sleep;
   end

   ////////////////////////////////////////////////////////////////////////////
   // link capability of the variant
   always_comb begin
      if (spi_variant) begin
         O_LINK_MASTER_OK = 1'b1;
         O_MAX_LINKS      = `BMS_LINKS_SPI;
      end else begin
         O_LINK_MASTER_OK = 1'b0;
         O_MAX_LINKS      = `BMS_LINKS_SLAVE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // select pin left open on the device side
   assign B.sel_dev_out = 1'b0;
   assign B.sel_dev_oe  = 1'b0;

endmodule

// File: core/bms_host.sv
// Purpose: host side driving straps, reset and wake to the radio module
// Assumes: I_MODE_REQ and I_STANDALONE_RX stable while a reboot runs
// Notes:   a reboot request pulses reset and re-applies the straps
`timescale 1ns/1ps
`include "bms_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module bms_host #(
   parameter int PWR_WAIT_CYC = `BMS_PWR_WAIT_CYC
) (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_N,
   bms_if.host              B,
   input  wire logic        I_VARIANT,
   input  wire logic [1:0]  I_MODE_REQ,
   input  wire logic        I_STANDALONE_RX,
   input  wire logic        I_REBOOT,
   input  wire logic        I_WAKE,
   output logic             O_READY
);
   bms_pkg::bms_host_t r;
   bms_pkg::bms_host_t next_r;
   logic rx_pick;
   logic sel_pick;

   always_comb begin
      rx_pick  = 1'b1;
      sel_pick = 1'b1;
      if (I_VARIANT == `BMS_VARIANT_SPI) begin
         rx_pick = I_MODE_REQ != 2'(bms_pkg::BMS_MODE_VENDOR);
      end else if (I_MODE_REQ == 2'(bms_pkg::BMS_MODE_APP)) begin
         sel_pick = 1'b0;
         rx_pick  = I_STANDALONE_RX;
      end
   end

   always_comb begin
      next_r           = r;
      next_r.wake      = I_WAKE;
      next_r.rx_level  = rx_pick;
      next_r.sel_level = sel_pick;
      case (r.st)
         bms_pkg::BMS_H_WAIT: begin
            next_r.rst_n = 1'b0;
            if (r.cnt >= 20'(PWR_WAIT_CYC - 1)) begin
               next_r.st  = bms_pkg::BMS_H_RUN;
               next_r.cnt = 20'h00000;
            end else begin
               next_r.cnt = r.cnt + 20'h00001;
            end
         end
         bms_pkg::BMS_H_PULSE: begin
            next_r.rst_n = 1'b0;
            if (r.cnt >= 20'(`BMS_RST_PULSE_CYC - 1)) begin
               next_r.st  = bms_pkg::BMS_H_RUN;
               next_r.cnt = 20'h00000;
            end else begin
               next_r.cnt = r.cnt + 20'h00001;
            end
         end
         bms_pkg::BMS_H_RUN: begin
            next_r.rst_n = 1'b1;
            if (I_REBOOT) begin
               next_r.st    = bms_pkg::BMS_H_PULSE;
               next_r.rst_n = 1'b0;
            end
         end
         default: begin
            next_r.st = bms_pkg::BMS_H_WAIT;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r <= '{st: bms_pkg::BMS_H_WAIT, cnt: 20'h00000, rx_level: 1'b1,
                sel_level: 1'b1, wake: 1'b0, rst_n: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign B.rst_n   = r.rst_n;
   assign B.rx      = r.rx_level;
   assign B.wake    = r.wake;
   // pull low to request application mode on the non-SPI variant, else leave open
   assign B.sel_out = 1'b0;
   assign B.sel_oe  = !r.sel_level;
   assign O_READY   = r.st == bms_pkg::BMS_H_RUN;
endmodule

// File: dv/bms_asserts.sv
// Purpose: wire checks between the host end and the radio module end
// Assumes: one clock, host reset async low
// Notes:   a reboot pulse is at least 40 cycles at 40 MHz
`timescale 1ns/1ps
module bms_asserts #(
   parameter int PWR_WAIT_CYC = 50
) (
   input  wire logic I_CLOCK,
   input  wire logic I_RST_N,
   input  wire logic rst_n,
   input  wire logic rx,
   input  wire logic sel_out,
   input  wire logic sel_oe,
   input  wire logic sel_dev_oe,
   input  wire logic sel
);
   logic [19:0] low_cnt;
   logic        seen_run;
   ////////////////////////////////////////////////////////////////////////////////
   // cycles of reset pin low, and first release seen
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         low_cnt  <= 20'h0;
         seen_run <= 1'b0;
      end else begin
         low_cnt  <= rst_n ? 20'h0 : low_cnt + 20'h1;
         seen_run <= seen_run | rst_n;
      end
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   ////////////////////////////////////////////////////////////////////////////////
   property p_dev_sel_open; !sel_dev_oe; endproperty
   a_dev_sel_open: assert property (p_dev_sel_open) else $error("device drives select");
   property p_sel_pullup; !sel_oe && !sel_dev_oe |-> sel; endproperty
   a_sel_pullup: assert property (p_sel_pullup) else $error("select not pulled up");
   property p_sel_low; sel_oe |-> !sel_out && !sel; endproperty
   a_sel_low: assert property (p_sel_low) else $error("select drive not low");
   property p_rst_held; $rose(I_RST_N) |-> !rst_n [*8]; endproperty
   a_rst_held: assert property (p_rst_held) else $error("reset pin released early");
   property p_pwr_wait; $rose(rst_n) && !seen_run |-> low_cnt >= 20'(PWR_WAIT_CYC - 1); endproperty
   a_pwr_wait: assert property (p_pwr_wait) else $error("power wait too short");
   property p_rst_pulse; $rose(rst_n) |-> low_cnt >= 20'h27; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
   property p_rx_hold; $rose(rst_n) |=> $stable(rx) [*8]; endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive strap moved in boot");
   property p_sel_hold; $rose(rst_n) |=> $stable(sel) [*8]; endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select strap moved in boot");
endmodule

// File: dv/boot_mode_selector_tb_top.sv
// Purpose: boots both ends through every strap case and checks the mode
// Assumes: host power wait shortened to 50 cycles
// Notes:   table bits are variant, request, rx, addon, mode, standalone
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module boot_mode_selector_tb_top;
   logic       clk       = 1'b0;
   logic       sys_rst_n = 1'b0;
   logic       variant   = 1'b1;
   logic [1:0] mode_req  = 2'h1;
   logic       sa_rx     = 1'b0;
   logic       reboot    = 1'b0;
   logic       wake      = 1'b1;
   logic       osc_ok    = 1'b0;
   logic       addon     = 1'b0;
   logic       load_done = 1'b0;
   logic [1:0] mode, max_links, exp;
   logic       ready, booted, standalone, use_spi, use_uart, vendor_hci, at_cmd;
   logic       load_req, run_app, hostless, sleep, master_ok;
   logic [7:0] c;
   logic [7:0] tbl [9] = '{8'ha2, 8'hd4, 8'hf4, 8'h24, 8'h54, 8'h5c, 8'h67, 8'h77, 8'h7e};
   int         fails = 0;
   int         num_checks = 0;
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   bms_if bus ();
   bms_host #(.PWR_WAIT_CYC(50)) bms_host_i (.I_CLOCK(clk), .I_RST_N(sys_rst_n), .B(bus),
      .I_VARIANT(variant), .I_MODE_REQ(mode_req), .I_STANDALONE_RX(sa_rx),
      .I_REBOOT(reboot), .I_WAKE(wake), .O_READY(ready));
   bms_device bms_device_i (.I_CLOCK(clk), .I_RST_N(bus.rst_n), .B(bus), .I_VARIANT(variant),
      .I_OSC_STABLE(osc_ok), .I_CFG_ADDON(addon), .I_LOAD_DONE(load_done), .O_MODE(mode),
      .O_BOOTED(booted), .O_STANDALONE(standalone), .O_USE_SPI(use_spi),
      .O_USE_UART(use_uart), .O_VENDOR_HCI(vendor_hci), .O_AT_CMD(at_cmd),
      .O_LOAD_REQ(load_req), .O_RUN_APP(run_app), .O_HOSTLESS(hostless), .O_SLEEP(sleep),
      .O_LINK_MASTER_OK(master_ok), .O_MAX_LINKS(max_links));
   bms_asserts #(.PWR_WAIT_CYC(50)) bms_asserts_i (.I_CLOCK(clk), .I_RST_N(sys_rst_n),
      .rst_n(bus.rst_n), .rx(bus.rx), .sel_out(bus.sel_out), .sel_oe(bus.sel_oe),
      .sel_dev_oe(bus.sel_dev_oe), .sel(bus.sel));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_boot();
      for (int k = 0; k < 400 && booted !== 1'b1; k++) tick(1);
      `CHK("booted", 1'b1, booted)
      `CHK("ready", 1'b1, ready)
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(5);
      sys_rst_n = 1'b1;
      tick(100);
      `CHK("booted early", 1'b0, booted)
      osc_ok = 1'b1;
      wait_boot();
      for (int i = 0; i < 9; i++) begin
         c = tbl[i];
         {variant, mode_req, sa_rx, addon} = c[7:3];
         exp = c[2:1];
         load_done = 1'b0;
         tick(1);
         reboot = 1'b1;
         tick(1);
         reboot = 1'b0;
         tick(4);
         `CHK("mode in reset", bms_pkg::BMS_MODE_NONE, mode)
         wait_boot();
         `CHK("mode", exp, mode)
         `CHK("standalone", c[0], standalone)
         `CHK("hostless", c[0], hostless)
         `CHK("text cmd", exp == 2'h3 && !c[0], at_cmd)
         `CHK("links", variant ? 2'h2 : 2'h1, max_links)
         `CHK("master", variant, master_ok)
         if (exp == bms_pkg::BMS_MODE_HCI) begin
            `CHK("uart", 1'b1, use_uart)
            `CHK("vendor hci", 1'b1, vendor_hci)
         end
         `CHK("spi port", exp == 2'h1, use_spi)
         `CHK("uart port", !(exp == 2'h3 && c[0]), use_uart)
         `CHK("hci only", exp == 2'h2, vendor_hci)
         if (exp == bms_pkg::BMS_MODE_VENDOR) begin
            `CHK("vendor port", 1'b1, use_spi | use_uart)
         end
         `CHK("load req", exp == 2'h3, load_req)
         `CHK("run early", 1'b0, run_app)
         load_done = 1'b1;
         tick(2);
         `CHK("run app", exp == 2'h3, run_app)
         `CHK("load req off", 1'b0, load_req)
         wake = 1'b0;
         tick(8);
         `CHK("sleep", exp == 2'h2, sleep)
         wake = 1'b1;
         tick(8);
         `CHK("awake", 1'b0, sleep)
         mode_req = ~mode_req;
         sa_rx = ~sa_rx;
         tick(30);
         `CHK("mode held", exp, mode)
      end
      close_out();
   end
   initial begin
      #(25 * 30000);
      fails++;
      close_out();
   end
endmodule

// File: shared/bms_if.sv
// Purpose: strap, reset and wake wires between host and radio module
// Assumes: strap select is open drain with a pull-up when nobody drives
// Notes:   select wire level resolved here from the enables
`timescale 1ns/1ps
interface bms_if;
   logic rst_n;
   logic rx;
   logic sel_out;
   logic sel_oe;
   logic sel_dev_out;
   logic sel_dev_oe;
   logic sel;
   logic wake;
   // pull-up when no end drives the select pin
   assign sel = sel_dev_oe ? sel_dev_out : (sel_oe ? sel_out : 1'b1);
   modport dev  (input rst_n, input rx, input sel, input wake,
                 output sel_dev_out, output sel_dev_oe);
   modport host (output rst_n, output rx, output sel_out, output sel_oe, output wake,
                 input sel);
endinterface

// File: shared/bms_pkg.sv
// Purpose: types for the boot mode selector
// Assumes: nothing
// Notes:   mode and phase encodings fixed by declaration order, counting from 0
package bms_pkg;
   typedef enum logic [1:0] {BMS_MODE_NONE, BMS_MODE_VENDOR, BMS_MODE_HCI, BMS_MODE_APP}
      bms_mode_t;
   typedef enum logic [1:0] {BMS_ST_RESET, BMS_ST_OSC, BMS_ST_RUN} bms_dev_st_t;
   typedef enum logic [1:0] {BMS_H_WAIT, BMS_H_PULSE, BMS_H_RUN} bms_host_st_t;
   typedef struct packed {
      bms_dev_st_t st;
      logic [4:0]  osc_cnt;
      bms_mode_t   mode;
      logic        standalone;
      logic        rx_s1;
      logic        rx_s2;
      logic        sel_s1;
      logic        sel_s2;
      logic        wake_s1;
      logic        wake_s2;
      logic        sleep;
   } bms_dev_t;
   typedef struct packed {
      bms_host_st_t st;
      logic [19:0]  cnt;
      logic         rx_level;
      logic         sel_level;
      logic         wake;
      logic         rst_n;
   } bms_host_t;
endpackage

// File: shared/bms_regs.svh
// Purpose: constants for the boot mode selector
// Assumes: 40 MHz system clock
// Notes:   times are in their own unit, counts derived from them
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_CLK_MHZ          40
`define BMS_RST_PULSE_NS     1000
`define BMS_RST_PULSE_CYC    ((`BMS_RST_PULSE_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_PWR_WAIT_MS      20
`define BMS_PWR_WAIT_CYC     (`BMS_PWR_WAIT_MS * 1000 * `BMS_CLK_MHZ)
`define BMS_OSC_WAIT_CYC     16
`define BMS_VARIANT_SPI      1'b1
`define BMS_VARIANT_SLAVE    1'b0
`define BMS_LINKS_SPI        2'h2
`define BMS_LINKS_SLAVE      2'h1
`endif
